// file: hdl/ctu_edge_control.sv
// Operation
// - Edge-one status reads whether edge one occurred; software write drives it.
// - Edge-two input is edge-sensitive when sampling select is 1, else level.
// - Edge-two polarity 1 responds to rising, 0 to falling transitions.
// - Four-bit selector picks edge-two source among sixteen codes.
// - Module operates only while the enable bit is 1.
// - Stop-in-idle 1 halts operation in idle mode; 0 keeps running.
// - Edge delay generation only while time-generation enable is 1.
// - Edges pass only while edge gate enable is 1.
// - Unimplemented bits 17-16 and 14 read zero, writes ignored.
//
// The register addresses and the APB register port were chosen for this implementation.
`include "ctu_regs.svh"
module ctu_edge_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic edge_one_in,
    input wire ctu_pkg::ctu_sources_t sources,
    output logic module_active,
    output logic edge_two_status,
    output logic delay_active,
    output logic converter_discharge_enable,
    output logic edge_source_drive
);
    ctu_pkg::ctu_ctrl_t ctrl_reg;
    logic disch_reg;
    logic e2_reg;
    logic [1:0] e1_sync_reg;
    logic [15:0] src_vec;
    ctu_pkg::ctu_sources_t src_meta_reg;
    ctu_pkg::ctu_sources_t src_sync_reg;
    logic clk_toggle_reg;
    logic src_prev_reg;
    logic e1_prev_reg;
    logic sel_bit;
    logic qualified;
    logic e1_event;
    logic active;
    logic wr_ctrl;
    logic wr_stat;
    logic [31:0] ctrl_word;

    assign wr_ctrl = psel && penable && pwrite && paddr == `CTU_CTRL_OFFSET;
    assign wr_stat = psel && penable && pwrite && paddr == `CTU_STAT_OFFSET;
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != `CTU_CTRL_OFFSET
        && paddr != `CTU_STAT_OFFSET;

    // Gated enable: on and not halted by idle
    assign active = ctrl_reg.module_enable && !(ctrl_reg.stop_in_idle && idle_mode);
    assign module_active = active;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CTU_E1_BIT] = ctrl_reg.edge_one_status;
        ctrl_word[`CTU_E2MODE_BIT] = ctrl_reg.edge_two_sampling_select;
        ctrl_word[`CTU_E2POL_BIT] = ctrl_reg.edge_two_polarity;
        ctrl_word[`CTU_E2SEL_HI:`CTU_E2SEL_LO] = ctrl_reg.edge_two_source_select;
        ctrl_word[`CTU_ON_BIT] = ctrl_reg.module_enable;
        ctrl_word[`CTU_SIDL_BIT] = ctrl_reg.stop_in_idle;
        ctrl_word[`CTU_TIME_GENERATION_ENABLE_BIT] = ctrl_reg.time_generation_enable;
        ctrl_word[`CTU_EDGE_GATE_ENABLE_BIT] = ctrl_reg.edge_gate_enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `CTU_CTRL_OFFSET) begin
                prdata <= ctrl_word;
            end else if (paddr == `CTU_STAT_OFFSET) begin
                prdata <= {30'h0000_0000, e2_reg, disch_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Mux after the synchronisers, code order matches the selector encoding
    assign src_vec = {src_sync_reg.comparator, clk_toggle_reg, src_sync_reg.capture,
        src_sync_reg.pins, src_sync_reg.compare_one_event, src_sync_reg.timer_event};
    // A selector change may look like an edge; clear the flag after reprogramming
    assign sel_bit = src_vec[ctrl_reg.edge_two_source_select];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 1'b0;
            e1_sync_reg <= 2'h0;
            e1_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= sel_bit;
            e1_sync_reg <= {e1_sync_reg[0], edge_one_in};
            e1_prev_reg <= e1_sync_reg[1];
        end
    end

    // Every source synchronised before the mux, so no async bit reaches logic
    // Bus clock source is a half-rate toggle: a clock cannot sample itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            clk_toggle_reg <= 1'b0;
        end else begin
            src_meta_reg <= sources;
            src_sync_reg <= src_meta_reg;
            clk_toggle_reg <= !clk_toggle_reg;
        end
    end

    // Level mode qualifies on the active level, edge mode on the transition
    always_comb begin
        if (ctrl_reg.edge_two_sampling_select) begin
            qualified = ctrl_reg.edge_two_polarity
                ? (sel_bit && !src_prev_reg) : (!sel_bit && src_prev_reg);
        end else begin
            qualified = ctrl_reg.edge_two_polarity ? sel_bit : !sel_bit;
        end
    end

    assign e1_event = e1_sync_reg[1] && !e1_prev_reg && active && ctrl_reg.edge_gate_enable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.edge_two_sampling_select <= pwdata[`CTU_E2MODE_BIT];
                ctrl_reg.edge_two_polarity <= pwdata[`CTU_E2POL_BIT];
                ctrl_reg.edge_two_source_select <= pwdata[`CTU_E2SEL_HI:`CTU_E2SEL_LO];
                ctrl_reg.module_enable <= pwdata[`CTU_ON_BIT];
                ctrl_reg.stop_in_idle <= pwdata[`CTU_SIDL_BIT];
                ctrl_reg.time_generation_enable <= pwdata[`CTU_TIME_GENERATION_ENABLE_BIT];
                ctrl_reg.edge_gate_enable <= pwdata[`CTU_EDGE_GATE_ENABLE_BIT];
            end
            // Hardware set wins over software clear
            if (e1_event) begin
                ctrl_reg.edge_one_status <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_reg.edge_one_status <= pwdata[`CTU_E1_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e2_reg <= 1'b0;
            disch_reg <= 1'b0;
        end else begin
            if (qualified && active && ctrl_reg.edge_gate_enable) begin
                e2_reg <= 1'b1;
            end else if (wr_stat && !pwdata[`CTU_E2FLAG_BIT]) begin
                e2_reg <= 1'b0;
            end
            if (wr_stat) begin
                disch_reg <= pwdata[`CTU_DISCH_BIT];
            end
        end
    end

    assign edge_two_status = e2_reg;
    assign converter_discharge_enable = disch_reg;
    assign edge_source_drive = ctrl_reg.edge_one_status && active;
    // Delay runs between edge one and edge two
    assign delay_active = active && ctrl_reg.time_generation_enable
        && ctrl_reg.edge_one_status && !e2_reg;

    a_edge_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (qualified && active && ctrl_reg.edge_gate_enable) |=> e2_reg)
        else $error("edge two flag not set");
    a_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_reg.edge_gate_enable && !e2_reg && !wr_ctrl) |=> !e2_reg)
        else $error("blocked edge set flag");
    a_off_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.module_enable |-> !module_active && !delay_active)
        else $error("disabled module active");
    a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.stop_in_idle && idle_mode) |-> !module_active)
        else $error("idle did not halt");
    a_idle_run: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_reg.stop_in_idle && ctrl_reg.module_enable) |-> module_active)
        else $error("idle halted wrongly");
    a_time_generation_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.time_generation_enable |-> !delay_active)
        else $error("delay without enable");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(penable) && psel && !pwrite && paddr == `CTU_CTRL_OFFSET
        |-> prdata[17:16] == 2'h0 && prdata[14] == 1'b0)
        else $error("reserved bits nonzero");
    a_e1_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !e1_event) |=> ctrl_reg.edge_one_status == $past(pwdata[`CTU_E1_BIT]))
        else $error("edge one status write lost");
    a_rise_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.edge_two_sampling_select && ctrl_reg.edge_two_polarity && qualified)
        |-> sel_bit && !src_prev_reg)
        else $error("edge mode qualified wrongly");
    a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_stat && !pwdata[`CTU_E2FLAG_BIT]
        && !(qualified && active && ctrl_reg.edge_gate_enable)) |=> !e2_reg)
        else $error("edge two flag not cleared");
    a_e2_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (e2_reg && !wr_stat) |=> e2_reg)
        else $error("edge two flag dropped");
    a_e1_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.edge_one_status && !wr_ctrl) |=> ctrl_reg.edge_one_status)
        else $error("edge one flag dropped");
    a_e1_set: assert property (@(posedge pclk) disable iff (!presetn)
        e1_event |=> ctrl_reg.edge_one_status)
        else $error("edge one flag not set");
    a_level_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_reg.edge_two_sampling_select && (sel_bit == ctrl_reg.edge_two_polarity)
        && active && ctrl_reg.edge_gate_enable) |=> e2_reg)
        else $error("level mode did not set flag");
    c_edge2: cover property (@(posedge pclk) $rose(e2_reg));
    c_delay: cover property (@(posedge pclk) $rose(delay_active));
    c_idle_stop: cover property (@(posedge pclk) $fell(module_active) && idle_mode);
    c_level_set: cover property (@(posedge pclk)
        !ctrl_reg.edge_two_sampling_select && $rose(e2_reg));
    c_e1_set: cover property (@(posedge pclk) e1_event);
endmodule : ctu_edge_control

// file: hdl/ctu_regs.svh
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH
`define CTU_CTRL_OFFSET 12'h000
`define CTU_STAT_OFFSET 12'h004
`define CTU_CTRL_RESET 32'h0000_0000
`define CTU_CTRL_WMASK 32'h01fc_b800
`define CTU_E1_BIT 24
`define CTU_E2MODE_BIT 23
`define CTU_E2POL_BIT 22
`define CTU_E2SEL_HI 21
`define CTU_E2SEL_LO 18
`define CTU_ON_BIT 15
`define CTU_SIDL_BIT 13
`define CTU_TIME_GENERATION_ENABLE_BIT 12
`define CTU_EDGE_GATE_ENABLE_BIT 11
`define CTU_DISCH_BIT 0
`define CTU_E2FLAG_BIT 1
`define CTU_SEL_PERIPHERAL_BUS_CLOCK 4'hc
`define CTU_SEL_CMP2 4'he
`endif

// file: hdl/ctu_pkg.sv
package ctu_pkg;
    typedef struct packed {
        logic edge_one_status;
        logic edge_two_sampling_select;
        logic edge_two_polarity;
        logic [3:0] edge_two_source_select;
        logic module_enable;
        logic stop_in_idle;
        logic time_generation_enable;
        logic edge_gate_enable;
    } ctu_ctrl_t;
    typedef struct packed {
        logic [2:0] comparator;
        logic [2:0] capture;
        logic [6:0] pins;
        logic compare_one_event;
        logic timer_event;
    } ctu_sources_t;
endpackage : ctu_pkg

// file: verification/ctu_edge_control_tb_top.sv
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module ctu_edge_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_mode = 0;
    logic edge_one_in = 0, pready, pslverr, module_active, edge_two_status, delay_active;
    logic converter_discharge_enable, edge_source_drive, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    ctu_pkg::ctu_sources_t src = '0;
    int fails = 0;
    int tests_run = 0;
    ctu_edge_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .idle_mode, .edge_one_in, .sources(src), .module_active,
        .edge_two_status, .delay_active, .converter_discharge_enable, .edge_source_drive);
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Fields: e1, mode, pol, sel, on, idle stop, time_generation_enable, gate
    function automatic logic [31:0] cw(logic e1, logic md, logic pl, logic [3:0] sl, logic on,
        logic sd, logic tg, logic gt);
        return {7'h00, e1, md, pl, sl, 2'b00, on, 1'b0, sd, tg, gt, 11'h000};
    endfunction : cw
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle between accesses, also after clearing the enable bit
        @(posedge pclk);
    endtask : xfer
    // Sync chain is three cycles; six leaves margin
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask : settle
    task automatic arm(input logic [31:0] c, input logic [14:0] s);
        xfer(1'b1, 12'h000, c);
        src <= s;
        xfer(1'b1, 12'h004, 32'h0000_0000);
    endtask : arm
    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h000, 32'h0);
        `CHK(rdata, 32'h0000_0000, "control reset")
        `CHK(module_active, 1'b0, "inactive after reset")
        xfer(1'b1, 12'h000, 32'hffff_ffff);
        `CHK(slv, 1'b0, "mapped no error")
        xfer(1'b0, 12'h000, 32'h0);
        `CHK(rdata, 32'h01fc_b800, "control readback")
        `CHK(delay_active, 1'b1, "delay on")
        `CHK(edge_source_drive, 1'b1, "edge one drive")
        xfer(1'b1, 12'h000, cw(1, 1, 1, 4'he, 1, 0, 0, 1));
        `CHK(delay_active, 1'b0, "delay off")
        xfer(1'b1, 12'h000, cw(1, 1, 1, 4'he, 1, 0, 1, 1));
        `CHK(delay_active, 1'b1, "pulse delay armed")
        src <= 15'h2000;
        settle();
        `CHK(edge_two_status, 1'b1, "comparator two edge")
        `CHK(delay_active, 1'b0, "delay ends at edge two")
        src <= 15'h0000;
        xfer(1'b1, 12'h008, 32'hffff_ffff);
        `CHK(slv, 1'b1, "unmapped error")
        xfer(1'b0, 12'h008, 32'h0);
        `CHK(rdata, 32'h0000_0000, "unmapped read")
        idle_mode <= 1'b1;
        xfer(1'b1, 12'h000, cw(0, 1, 1, 0, 1, 1, 0, 1));
        `CHK(module_active, 1'b0, "halt in idle")
        `CHK(edge_source_drive, 1'b0, "edge one drive off")
        xfer(1'b1, 12'h000, cw(0, 1, 1, 0, 1, 0, 0, 1));
        `CHK(module_active, 1'b1, "run in idle")
        idle_mode <= 1'b0;
        xfer(1'b1, 12'h004, 32'h0000_0001);
        `CHK(converter_discharge_enable, 1'b1, "discharge")
        for (int c = 0; c < 16; c++) begin
            arm(cw(0, 1, 1, c[3:0], 1, 0, 0, 1), ~(15'h1 << (c > 12 ? c - 1 : c)));
            settle();
            if (c != 12) `CHK(edge_two_status, 1'b0, "other source ignored")
            src <= 15'h7fff;
            settle();
            `CHK(edge_two_status, 1'b1, "selected source edge")
            src <= 15'h0000;
            settle();
        end
        arm(cw(0, 1, 1, 0, 1, 0, 0, 0), 15'h0001);
        settle();
        `CHK(edge_two_status, 1'b0, "gate blocks")
        arm(cw(0, 1, 1, 0, 0, 0, 0, 1), 15'h0000);
        src <= 15'h0001;
        settle();
        `CHK(edge_two_status, 1'b0, "disabled blocks")
        arm(cw(0, 1, 0, 0, 1, 0, 0, 1), 15'h0001);
        settle();
        xfer(1'b1, 12'h004, 32'h0);
        src <= 15'h0000;
        settle();
        `CHK(edge_two_status, 1'b1, "falling edge")
        arm(cw(0, 1, 1, 0, 1, 0, 0, 1), 15'h0001);
        settle();
        xfer(1'b1, 12'h004, 32'h0);
        settle();
        `CHK(edge_two_status, 1'b0, "edge mode held high")
        xfer(1'b1, 12'h000, cw(0, 0, 1, 0, 1, 0, 0, 1));
        xfer(1'b1, 12'h004, 32'h0);
        settle();
        `CHK(edge_two_status, 1'b1, "level mode")
        xfer(1'b0, 12'h004, 32'h0);
        `CHK(rdata, 32'h0000_0002, "status readback")
        edge_one_in <= 1'b1;
        settle();
        xfer(1'b0, 12'h000, 32'h0);
        `CHK(rdata[24], 1'b1, "edge one seen")
        `CHK(edge_source_drive, 1'b1, "edge one drives source")
        conclude();
    end
endmodule : ctu_edge_control_tb_top
